/* File: common/shift_rotate_pkg.sv */
/*
  package for the shift and rotate unit: operation codes, operand widths,
  field positions, reset values and timing counts.
  assumes every file names its items as shift_rotate_pkg::name.
*/
package shift_rotate_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 20;

  // operand sizes
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int DWORD_W = 32;
  localparam int COUNT_W = 8;

  // bit shift register limits
  localparam int BSR_MAX_LEN = 64;
  localparam int BSR_LEN_W = 8;
  localparam int BSR_IDX_W = 6;
  localparam int BITS_PER_BYTE = 8;
  localparam int BSR_BYTE_OFS_W = 4;
  localparam int BSR_BIT_IDX_W = 3;

  // operation codes
  typedef enum logic [3:0] {
    OP_SHL_B = 4'h0,
    OP_SHR_B = 4'h1,
    OP_SHL_W = 4'h2,
    OP_SHR_W = 4'h3,
    OP_SHL_D = 4'h4,
    OP_SHR_D = 4'h5,
    OP_ROL_B = 4'h6,
    OP_ROR_B = 4'h7,
    OP_ROL_W = 4'h8,
    OP_ROR_W = 4'h9,
    OP_ROL_D = 4'ha,
    OP_ROR_D = 4'hb,
    OP_BSR = 4'hc
  } op_t;

  // operand size selector
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_DWORD = 2'h2
  } size_t;

  // reset values
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic ZERO_FLAG_RST = 1'b0;
  localparam logic OVERFLOW_FLAG_RST = 1'b0;
  localparam logic [63:0] BSR_RST = 64'h0000_0000_0000_0000;

endpackage : shift_rotate_pkg

/* File: design/word_shifter.sv */
/*
  combinational shifter and rotator for byte, word and double-word operands.
  assumes the caller registers the outputs; operands sit in the low bits.
*/
`timescale 1ns/1ps
module word_shifter (
  input wire shift_rotate_pkg::size_t size,
  input wire logic is_rotate,
  input wire logic dir_left,
  input wire logic [31:0] value,
  input wire logic [7:0] count,
  output logic [31:0] result,
  output logic shifted,
  output logic last_bit
);

  function automatic int width_of(shift_rotate_pkg::size_t s);
    unique case (s)
      shift_rotate_pkg::SZ_BYTE: width_of = shift_rotate_pkg::BYTE_W;
      shift_rotate_pkg::SZ_WORD: width_of = shift_rotate_pkg::WORD_W;
      default: width_of = shift_rotate_pkg::DWORD_W;
    endcase
  endfunction

  always_comb begin
    int w;
    int n;
    logic [63:0] wide;
    logic [31:0] mask;
    w = width_of(size);
    n = 0;
    wide = 64'h0;
    mask = (w == 32) ? 32'hffff_ffff : ((32'h1 << w) - 32'h1);
    result = value & mask;
    shifted = 1'b0;
    last_bit = 1'b0;
    if (is_rotate) begin
      n = int'(count) % w; // RULE13 RULE14 RULE15
      if (n != 0) begin
        shifted = 1'b1; // RULE16
        if (dir_left) begin
          wide = {32'h0, value & mask} << n;
          result = (wide[31:0] | 32'(wide >> w)) & mask;
          last_bit = result[0];
        end else begin
          wide = {value & mask, 32'h0} >> n;
          result = (wide[63:32] | (wide[31:0] >> (32 - w))) & mask;
          last_bit = result[w-1];
        end
      end
    end else begin
      n = (int'(count) >= w) ? w : int'(count); // RULE9 RULE10 RULE11
      if (n != 0) begin
        shifted = 1'b1; // RULE12
        if (dir_left) begin
          wide = {32'h0, value & mask} << n; // RULE8
          result = wide[31:0] & mask;
          last_bit = wide[w];
        end else begin
          wide = {value & mask, 32'h0} >> n; // RULE8
          result = wide[63:32];
          last_bit = wide[31];
        end
      end
    end
  end

endmodule // word_shifter

/* File: design/bit_shift_register.sv */
/*
  bit shift register storage of up to 64 bits with signed length.
  assumes the caller presents a nonzero length no larger than the maximum.
*/
`timescale 1ns/1ps
module bit_shift_register #(
  parameter int MAX_LEN = shift_rotate_pkg::BSR_MAX_LEN
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic data_in,
  input wire logic signed [7:0] len,
  output logic out_bit,
  output logic [MAX_LEN-1:0] bits
);

  typedef struct packed {
    logic [MAX_LEN-1:0] reg_bits;
  } bsr_state_t;

  bsr_state_t s_q, s_d;

  always_comb begin
    int mag;
    logic [MAX_LEN-1:0] up;
    logic [MAX_LEN-1:0] dn;
    mag = (len < 0) ? -int'(len) : int'(len);
    // neighbours precomputed so no bit select runs past either end
    up = {s_q.reg_bits[MAX_LEN-2:0], data_in};
    dn = {1'b0, s_q.reg_bits[MAX_LEN-1:1]};
    if (mag > MAX_LEN) begin
      mag = MAX_LEN; // RULE5
    end
    s_d = s_q;
    out_bit = 1'b0;
    if (mag != 0) begin
      if (len < 0) begin
        out_bit = s_q.reg_bits[0]; // RULE2
      end else begin
        out_bit = s_q.reg_bits[mag-1]; // RULE3
      end
    end
    if (step && mag != 0) begin
      for (int i = 0; i < MAX_LEN; i++) begin
        if (i < mag) begin
          if (len < 0) begin
            s_d.reg_bits[i] = (i == mag - 1) ? data_in : dn[i]; // RULE2
          end else begin
            s_d.reg_bits[i] = up[i]; // RULE3
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q.reg_bits <= '0;
    end else begin
      s_q <= s_d; // RULE6
    end
  end

  assign bits = s_q.reg_bits;

endmodule // bit_shift_register

/* File: design/shift_rotate_unit.sv */
/*
  shift and rotate execution unit: byte, word and double-word shifts and
  rotates plus a bit shift register of up to 64 bits.
  assumes a sequencer pulses exec_en once per instruction with operands
  steady in that cycle, and samples the flags the cycle after.
*/
//Contract
//RULE1: shift one data bit into bit register
//RULE2: negative length enters at top, exits bottom
//RULE3: positive length enters at bottom, exits top
//RULE4: bit removed goes into overflow flag
//RULE5: register length magnitude up to 64 bits
//RULE6: one bit position per execution
//RULE7: top bit location from start plus length
//RULE8: shifts zero fill, unsigned, to result
//RULE9: byte shift count saturates at eight
//RULE10: word shift count saturates at sixteen
//RULE11: double-word count saturates at thirty-two
//RULE12: nonzero shift count sets overflow to last out
//RULE13: byte rotate count modulo eight
//RULE14: word rotate count modulo sixteen
//RULE15: double-word rotate count modulo thirty-two
//RULE16: zero rotate does nothing, else overflow last
//RULE17: every shift or rotate updates both flags; the code updates overflow only when the shift or rotate amount is nonzero
//RULE18: zero flag on zero result, overflow held
//RULE19: sequencer pulses enable and supplies operands
`timescale 1ns/1ps
module shift_rotate_unit #(
  parameter int BSR_LEN = shift_rotate_pkg::BSR_MAX_LEN
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic exec_en,
  input wire shift_rotate_pkg::op_t op,
  input wire logic [31:0] in_value,
  input wire logic [7:0] count,
  input wire logic data_bit,
  input wire logic [7:0] start_byte,
  input wire logic [2:0] start_bit,
  input wire logic signed [7:0] bsr_length,
  output logic [31:0] result,
  output logic result_valid,
  output logic zero_flag_bit,
  output logic overflow_flag_bit,
  output logic [7:0] msb_byte_addr,
  output logic [2:0] msb_bit_idx,
  output logic [BSR_LEN-1:0] bsr_bits
);

  typedef struct packed {
    logic [31:0] result;
    logic valid;
    logic zero;
    logic ovf;
    logic [7:0] msb_byte;
    logic [2:0] msb_bit;
    logic [BSR_LEN-1:0] bsr_view;
  } unit_state_t;

  unit_state_t s_q, s_d;

  shift_rotate_pkg::size_t op_size;
  logic op_rotate;
  logic op_left;
  logic op_is_bsr;
  logic [31:0] shr_result;
  logic shr_shifted;
  logic shr_last;
  logic bsr_out;
  logic [BSR_LEN-1:0] bsr_now;

  // one decode shared by the shifter and the flag logic
  function automatic logic [3:0] decode_op(shift_rotate_pkg::op_t o);
    unique case (o)
      shift_rotate_pkg::OP_SHL_B: decode_op = {2'h0, 1'b0, 1'b1};
      shift_rotate_pkg::OP_SHR_B: decode_op = {2'h0, 1'b0, 1'b0};
      shift_rotate_pkg::OP_SHL_W: decode_op = {2'h1, 1'b0, 1'b1};
      shift_rotate_pkg::OP_SHR_W: decode_op = {2'h1, 1'b0, 1'b0};
      shift_rotate_pkg::OP_SHL_D: decode_op = {2'h2, 1'b0, 1'b1};
      shift_rotate_pkg::OP_SHR_D: decode_op = {2'h2, 1'b0, 1'b0};
      shift_rotate_pkg::OP_ROL_B: decode_op = {2'h0, 1'b1, 1'b1};
      shift_rotate_pkg::OP_ROR_B: decode_op = {2'h0, 1'b1, 1'b0};
      shift_rotate_pkg::OP_ROL_W: decode_op = {2'h1, 1'b1, 1'b1};
      shift_rotate_pkg::OP_ROR_W: decode_op = {2'h1, 1'b1, 1'b0};
      shift_rotate_pkg::OP_ROL_D: decode_op = {2'h2, 1'b1, 1'b1};
      shift_rotate_pkg::OP_ROR_D: decode_op = {2'h2, 1'b1, 1'b0};
      default: decode_op = {2'h0, 1'b0, 1'b0};
    endcase
  endfunction

  logic [3:0] dec;
  assign dec = decode_op(op);
  assign op_size = shift_rotate_pkg::size_t'(dec[3:2]);
  assign op_rotate = dec[1];
  assign op_left = dec[0];
  assign op_is_bsr = (op == shift_rotate_pkg::OP_BSR);

  word_shifter u_shifter (
    .size(op_size),
    .is_rotate(op_rotate),
    .dir_left(op_left),
    .value(in_value),
    .count(count),
    .result(shr_result),
    .shifted(shr_shifted),
    .last_bit(shr_last)
  );

  bit_shift_register #(
    .MAX_LEN(BSR_LEN)
  ) u_bsr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(exec_en && op_is_bsr), // RULE1
    .data_in(data_bit),
    .len(bsr_length),
    .out_bit(bsr_out),
    .bits(bsr_now)
  );

  always_comb begin
    logic [7:0] mag;
    logic [11:0] sum;
    mag = (bsr_length < 0) ? 8'(-bsr_length) : 8'(bsr_length);
    // same clamp as the store, so the reported top bit matches it
    if (mag > 8'(BSR_LEN)) begin
      mag = 8'(BSR_LEN); // RULE5
    end
    sum = 12'(mag) - 12'h1 + 12'(start_bit); // RULE7
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.bsr_view = bsr_now;
    if (exec_en) begin
      s_d.valid = 1'b1;
      if (op_is_bsr) begin
        if (mag != 8'h0) begin
          s_d.ovf = bsr_out; // RULE4
          s_d.msb_byte = 8'(start_byte + 8'(sum >> 3)); // RULE7
          s_d.msb_bit = sum[2:0]; // RULE7
        end
      end else begin
        s_d.result = shr_result; // RULE8
        s_d.zero = (shr_result == 32'h0); // RULE17 RULE18
        if (shr_shifted) begin
          s_d.ovf = shr_last; // RULE12 RULE16 RULE17
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q.result <= shift_rotate_pkg::RESULT_RST;
      s_q.valid <= 1'b0;
      s_q.zero <= shift_rotate_pkg::ZERO_FLAG_RST;
      s_q.ovf <= shift_rotate_pkg::OVERFLOW_FLAG_RST;
      s_q.msb_byte <= 8'h00;
      s_q.msb_bit <= 3'h0;
      s_q.bsr_view <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign result = s_q.result;
  assign result_valid = s_q.valid;
  assign zero_flag_bit = s_q.zero;
  assign overflow_flag_bit = s_q.ovf;
  assign msb_byte_addr = s_q.msb_byte;
  assign msb_bit_idx = s_q.msb_bit;
  assign bsr_bits = s_q.bsr_view;

endmodule // shift_rotate_unit

/* File: tb/seq_model.sv */
/*
  sequencer model: issues one instruction to the unit per call.
  assumes the unit samples its inputs on the rising edge of ref_clk.
*/
`timescale 1ns/1ps
module seq_model (
  input wire logic ref_clk,
  output logic exec_en,
  output shift_rotate_pkg::op_t op,
  output logic [31:0] in_value,
  output logic [7:0] count,
  output logic data_bit,
  output logic [7:0] start_byte,
  output logic [2:0] start_bit,
  output logic signed [7:0] bsr_length
);
  initial begin
    exec_en = 1'b0;
    op = shift_rotate_pkg::OP_SHL_B;
    {in_value, count, data_bit, start_byte, start_bit, bsr_length} = '0;
  end
  task automatic place(input logic [7:0] b, input logic [2:0] i);
    start_byte = b;
    start_bit = i;
  endtask
  // operands stay put after the pulse, only the enable drops
  task automatic issue(input shift_rotate_pkg::op_t o, input logic [31:0] v,
      input logic [7:0] c, input logic d, input logic signed [7:0] n);
    @(posedge ref_clk);
    #1;
    op = o;
    in_value = v;
    count = c;
    data_bit = d;
    bsr_length = n;
    exec_en = 1'b1;
    @(posedge ref_clk);
    #1;
    exec_en = 1'b0;
  endtask
endmodule // seq_model

/* File: tb/shift_rotate_unit_asserts.sv */
/*
  port checker for the shift and rotate unit.
  assumes it is bound into every unit instance.
*/
`timescale 1ns/1ps
module shift_rotate_unit_asserts (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic exec_en,
  input wire shift_rotate_pkg::op_t op,
  input wire logic [31:0] in_value,
  input wire logic [7:0] count,
  input wire logic [7:0] start_byte,
  input wire logic [2:0] start_bit,
  input wire logic signed [7:0] bsr_length,
  input wire logic [31:0] result,
  input wire logic result_valid,
  input wire logic zero_flag_bit,
  input wire logic overflow_flag_bit,
  input wire logic [7:0] msb_byte_addr,
  input wire logic [2:0] msb_bit_idx
);
  logic [8:0] top_sum;
  logic [7:0] top_byte;
  logic [2:0] top_bit;
  logic pos_len;
  // positive lengths only, so the unsigned sum is exact
  assign top_sum = 9'(start_bit) + 9'(bsr_length) - 9'h1;
  assign top_byte = start_byte + 8'(top_sum[8:3]);
  assign top_bit = top_sum[2:0];
  assign pos_len = bsr_length > 8'sd0 && bsr_length <= 8'sd64;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_valid_pulse: assert property (exec_en |=> result_valid)
    else $error("no result_valid");
  a_byte_sat: assert property (
    exec_en && op == shift_rotate_pkg::OP_SHL_B && count >= 8'h8 |=>
    result == 32'h0 && overflow_flag_bit == $past(in_value[0]))
    else $error("byte shift not saturated");
  a_word_sat: assert property (
    exec_en && op == shift_rotate_pkg::OP_SHR_W && count >= 8'h10 |=>
    result == 32'h0 && overflow_flag_bit == $past(in_value[15]))
    else $error("word shift not saturated");
  a_dword_sat: assert property (
    exec_en && op == shift_rotate_pkg::OP_SHL_D && count >= 8'h20 |=>
    result == 32'h0 && overflow_flag_bit == $past(in_value[0]))
    else $error("dword shift not saturated");
  a_zero_flag: assert property (
    exec_en && op != shift_rotate_pkg::OP_BSR |=>
    zero_flag_bit == (result == 32'h0)) else $error("zero flag wrong");
  a_rot_none: assert property (
    exec_en && op == shift_rotate_pkg::OP_ROR_B && count[2:0] == 3'h0 |=>
    $stable(overflow_flag_bit) && result == {24'h0, $past(in_value[7:0])})
    else $error("zero rotate changed state");
  a_idle_hold: assert property (
    !exec_en |=> $stable(result) && $stable(overflow_flag_bit))
    else $error("outputs moved while idle");
  a_top_bit: assert property (
    exec_en && op == shift_rotate_pkg::OP_BSR && pos_len |=>
    msb_bit_idx == $past(top_bit) && msb_byte_addr == $past(top_byte))
    else $error("top bit location wrong");
  c_bsr: cover property (exec_en && op == shift_rotate_pkg::OP_BSR);
  c_ror_w: cover property (exec_en && op == shift_rotate_pkg::OP_ROR_W);
  c_big: cover property (exec_en && count >= 8'h20);
endmodule // shift_rotate_unit_asserts

bind shift_rotate_unit shift_rotate_unit_asserts u_chk (.ref_clk, .rst_n,
  .exec_en, .op, .in_value, .count, .start_byte, .start_bit, .bsr_length,
  .result, .result_valid, .zero_flag_bit, .overflow_flag_bit,
  .msb_byte_addr, .msb_bit_idx);

/* File: tb/tb.sv */
/*
  self-checking bench for the shift and rotate unit.
  assumes the sequencer model drives every instruction input.
*/
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic exec_en, data_bit, result_valid, zero_flag_bit, overflow_flag_bit;
  shift_rotate_pkg::op_t op;
  logic [31:0] in_value, result;
  logic [7:0] count, start_byte, msb_byte_addr;
  logic [2:0] start_bit, msb_bit_idx;
  logic signed [7:0] bsr_length;
  logic [63:0] bsr_bits;
  int n_errors = 0;
  int checked = 0;
  always #10 ref_clk = ~ref_clk;
  seq_model u_seq (.ref_clk, .exec_en, .op, .in_value, .count, .data_bit,
    .start_byte, .start_bit, .bsr_length);
  shift_rotate_unit u_dut (.ref_clk, .rst_n, .exec_en, .op, .in_value,
    .count, .data_bit, .start_byte, .start_bit, .bsr_length, .result,
    .result_valid, .zero_flag_bit, .overflow_flag_bit, .msb_byte_addr,
    .msb_bit_idx, .bsr_bits);
  task automatic chk(input string what, input logic [63:0] e,
      input logic [63:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    chk("reset result", shift_rotate_pkg::RESULT_RST, result);
    chk("reset ovf", shift_rotate_pkg::OVERFLOW_FLAG_RST, overflow_flag_bit);
    chk("reset zero", shift_rotate_pkg::ZERO_FLAG_RST, zero_flag_bit);
    chk("reset valid", 1'b0, result_valid);
  endtask
  task automatic op_chk(input shift_rotate_pkg::op_t o, input logic [31:0] v,
      input logic [7:0] c, input logic [31:0] r, input logic f);
    u_seq.issue(o, v, c, 1'b0, 8'sd0);
    chk("valid", 1'b1, result_valid);
    chk("result", r, result);
    chk("zero", r == 32'h0, zero_flag_bit);
    chk("ovf", f, overflow_flag_bit);
  endtask
  task automatic t_shift;
    op_chk(shift_rotate_pkg::OP_SHL_B, 32'h81, 8'h1, 32'h2, 1'b1);
    op_chk(shift_rotate_pkg::OP_SHR_B, 32'h81, 8'h7, 32'h1, 1'b0);
    op_chk(shift_rotate_pkg::OP_SHL_B, 32'h81, 8'hc8, 32'h0, 1'b1);
    op_chk(shift_rotate_pkg::OP_SHL_W, 32'hff, 8'h4, 32'hff0, 1'b0);
    op_chk(shift_rotate_pkg::OP_SHR_W, 32'h8001, 8'h10, 32'h0, 1'b1);
    op_chk(shift_rotate_pkg::OP_SHL_D, 32'h1, 8'hff, 32'h0, 1'b1);
    op_chk(shift_rotate_pkg::OP_SHR_D, 32'h4000_0000, 8'h20, 32'h0, 1'b0);
    // an unused code must act as a byte shift right
    op_chk(shift_rotate_pkg::op_t'(4'hd), 32'h81, 8'h1, 32'h40, 1'b1);
  endtask
  task automatic t_rotate;
    op_chk(shift_rotate_pkg::OP_ROL_B, 32'h81, 8'h9, 32'h3, 1'b1);
    op_chk(shift_rotate_pkg::OP_ROR_B, 32'h81, 8'hf, 32'h3, 1'b0);
    op_chk(shift_rotate_pkg::OP_ROR_W, 32'h1, 8'h11, 32'h8000, 1'b1);
    op_chk(shift_rotate_pkg::OP_ROL_W, 32'h8000, 8'h10, 32'h8000, 1);
    op_chk(shift_rotate_pkg::OP_ROR_D, 32'h3, 8'h3f, 32'h6, 1'b0);
    op_chk(shift_rotate_pkg::OP_ROL_D, 32'h8000_0000, 8'h21, 32'h1, 1'b1);
    op_chk(shift_rotate_pkg::OP_ROR_B, 32'h0, 8'h8, 32'h0, 1'b1);
  endtask
  task automatic t_bsr_plus;
    logic [4:0] pat;
    pat = 5'h0d;
    u_seq.place(8'h5, 3'h6);
    for (int i = 0; i < 5; i++) begin
      u_seq.issue(shift_rotate_pkg::OP_BSR, 32'h0, 8'h0, pat[i], 8'sd4);
      chk("bsr out", i == 4, overflow_flag_bit);
    end
    chk("top byte", 8'h6, msb_byte_addr);
    chk("top bit", 3'h1, msb_bit_idx);
    chk("bsr zero", 1'b1, zero_flag_bit);
    @(posedge ref_clk);
    #1;
    chk("bsr bits", 4'h6, bsr_bits[3:0]);
  endtask
  task automatic t_bsr_minus;
    do_reset();
    u_seq.place(8'h0, 3'h0);
    // one set bit must walk the full 64 positions before it drops out
    for (int i = 0; i < 65; i++) begin
      u_seq.issue(shift_rotate_pkg::OP_BSR, 32'h0, 8'h0, i == 0, -8'sd64);
      chk("bsr out", i == 64, overflow_flag_bit);
      if (i == 0) begin
        chk("top", 11'h3f, {msb_byte_addr, msb_bit_idx});
      end
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000;
    n_errors++;
    $display("unexpected timeout: expected done seen hang");
    close_out();
  end
  initial begin
    do_reset();
    t_shift();
    t_rotate();
    t_bsr_plus();
    t_bsr_minus();
    close_out();
  end
endmodule // tb
